// File: design/rcr_top.sv
`timescale 1ns/100ps
module rcr_top (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Reset and wake sources and sleep command, one-cycle pulses
    input wire logic por_event,
    input wire logic bor_event,
    input wire logic external_reset_pin,
    input wire logic wdt_timeout,
    input wire logic soft_reset,
    input wire logic stack_overflow,
    input wire logic stack_underflow,
    input wire logic wake_interrupt,
    input wire logic sleep_cmd,
    // Core program flow
    input wire logic [15:0] cur_pc,
    input wire logic instr_done,
    output logic core_reset,
    output logic pc_load,
    output logic [15:0] pc_value,
    output logic return_push,
    output logic [15:0] return_addr,
    output logic asleep,
    // Avalon-MM slave
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Interrupt
    output logic irq
);

    // ==========================================================
    // State
    rcr_pkg::rcr_state_t state_reg;
    rcr_pkg::rcr_state_t state_next;
    logic time_out_flag_reg;
    logic time_out_flag_next;
    logic power_down_flag_reg;
    logic power_down_flag_next;
    logic [7:0] power_control_register_reg;
    logic [7:0] power_control_register_next;
    logic [1:0] ctrl_reg;
    logic [1:0] ctrl_next;
    logic [15:0] pc_value_reg;
    logic [15:0] pc_value_next;
    logic [15:0] return_addr_reg;
    logic [15:0] return_addr_next;
    logic core_reset_reg;
    logic core_reset_next;
    logic pc_load_reg;
    logic pc_load_next;
    logic return_push_reg;
    logic return_push_next;

    // Bus side
    logic wr_en;
    logic [31:0] rd_value;
    logic [7:0] ev_set;
    logic [7:0] irq_status;
    logic [7:0] irq_mask;
    logic lane0;

    // Decoded events, one at most per cycle
    logic stack_error_reset_enable;
    logic global_interrupt_enable;
    logic sel_por;
    logic sel_bor;
    logic sel_pin;
    logic sel_wdt;
    logic sel_ovf;
    logic sel_unf;
    logic sel_soft;
    logic sel_wake;
    logic sel_sleep;
    logic in_sleep;

    assign stack_error_reset_enable = ctrl_reg[rcr_pkg::RCR_CT_STKEN];
    assign global_interrupt_enable = ctrl_reg[rcr_pkg::RCR_CT_GIE];
    assign in_sleep = (state_reg == rcr_pkg::RCR_SLEEP);
    assign lane0 = wr_en & avs_byteenable[0];

    // ==========================================================
    // Source priority: power-on beats everything, sleep entry is last
    always_comb begin
        sel_por = por_event;
        sel_bor = !sel_por && bor_event;
        sel_pin = !sel_por && !sel_bor && external_reset_pin;
        sel_wdt = !sel_por && !sel_bor && !sel_pin && wdt_timeout;
        sel_ovf = !sel_por && !sel_bor && !sel_pin && !sel_wdt
                  && stack_overflow && stack_error_reset_enable;
        sel_unf = !sel_por && !sel_bor && !sel_pin && !sel_wdt && !sel_ovf
                  && stack_underflow && stack_error_reset_enable;
        sel_soft = !sel_por && !sel_bor && !sel_pin && !sel_wdt
                   && !sel_ovf && !sel_unf && soft_reset;
        sel_wake = !sel_por && !sel_bor && !sel_pin && !sel_wdt
                   && !sel_ovf && !sel_unf && !sel_soft
                   && wake_interrupt && in_sleep;
        sel_sleep = !sel_por && !sel_bor && !sel_pin && !sel_wdt
                    && !sel_ovf && !sel_unf && !sel_soft && !wake_interrupt
                    && sleep_cmd && (state_reg == rcr_pkg::RCR_RUN);
    end

    // ==========================================================
    // Cause flags, resume address and core control
    always_comb begin
        state_next = state_reg;
        time_out_flag_next = time_out_flag_reg;
        power_down_flag_next = power_down_flag_reg;
        power_control_register_next = power_control_register_reg;
        ctrl_next = ctrl_reg;
        pc_value_next = pc_value_reg;
        return_addr_next = return_addr_reg;
        core_reset_next = 1'b0;
        pc_load_next = 1'b0;
        return_push_next = 1'b0;

        // Software writes come first so a same-cycle event overrides them
        if (lane0 && avs_address == rcr_pkg::RCR_OFS_POWER_CONTROL_REGISTER) begin
            power_control_register_next =
                (power_control_register_reg & ~rcr_pkg::RCR_POWER_CONTROL_REGISTER_WMASK)
                | (avs_writedata[7:0] & rcr_pkg::RCR_POWER_CONTROL_REGISTER_WMASK);
        end
        if (lane0 && avs_address == rcr_pkg::RCR_OFS_CTRL) begin
            ctrl_next = avs_writedata[1:0];
        end

        if (sel_por) begin
            power_control_register_next = rcr_pkg::RCR_POWER_CONTROL_REGISTER_POR;
            time_out_flag_next = rcr_pkg::RCR_TO_POR;
            power_down_flag_next = rcr_pkg::RCR_PD_POR;
        end else if (sel_bor) begin
            power_control_register_next[rcr_pkg::RCR_PC_OVF] = 1'b0;
            power_control_register_next[rcr_pkg::RCR_PC_UNF] = 1'b0;
            power_control_register_next[rcr_pkg::RCR_PC_PIN_N] = 1'b1;
            power_control_register_next[rcr_pkg::RCR_PC_SOFT_N] = 1'b1;
            power_control_register_next[rcr_pkg::RCR_PC_BOR_N] = 1'b0;
            time_out_flag_next = 1'b1;
            power_down_flag_next = 1'b1;
        end else if (sel_pin) begin
            power_control_register_next[rcr_pkg::RCR_PC_PIN_N] = 1'b0;
            if (in_sleep) begin
                time_out_flag_next = 1'b1;
                power_down_flag_next = 1'b0;
            end
        end else if (sel_wdt) begin
            time_out_flag_next = 1'b0;
            if (in_sleep) begin
                power_down_flag_next = 1'b0;
            end else begin
                power_control_register_next[rcr_pkg::RCR_PC_WDT_N] = 1'b0;
            end
        end else if (sel_ovf) begin
            power_control_register_next[rcr_pkg::RCR_PC_OVF] = 1'b1;
        end else if (sel_unf) begin
            power_control_register_next[rcr_pkg::RCR_PC_UNF] = 1'b1;
        end else if (sel_soft) begin
            power_control_register_next[rcr_pkg::RCR_PC_SOFT_N] = 1'b0;
        end else if (sel_wake) begin
            time_out_flag_next = 1'b1;
            power_down_flag_next = 1'b0;
        end else if (sel_sleep) begin
            // Sleep entry arms the flags that a wake then tells apart
            time_out_flag_next = 1'b1;
            power_down_flag_next = 1'b0;
        end

        // Program flow: restart, resume or vector
        if (sel_por || sel_bor || sel_pin || sel_ovf || sel_unf || sel_soft
            || (sel_wdt && !in_sleep)) begin
            core_reset_next = 1'b1;
            pc_load_next = 1'b1;
            pc_value_next = rcr_pkg::RCR_RESET_ADDR;
            state_next = rcr_pkg::RCR_RUN;
        end else if (sel_wdt || sel_wake) begin
            pc_load_next = 1'b1;
            pc_value_next = cur_pc + rcr_pkg::RCR_PC_STEP;
            state_next = (sel_wake && global_interrupt_enable)
                         ? rcr_pkg::RCR_WAKE_EXEC : rcr_pkg::RCR_RUN;
        end else if (sel_sleep) begin
            state_next = rcr_pkg::RCR_SLEEP;
        end else begin
            case (state_reg)
                rcr_pkg::RCR_WAKE_EXEC: begin
                    // One instruction runs before the vector is taken
                    if (instr_done) begin
                        return_push_next = 1'b1;
                        return_addr_next = pc_value_reg
                                           + rcr_pkg::RCR_PC_STEP;
                        pc_load_next = 1'b1;
                        pc_value_next = rcr_pkg::RCR_INT_VECTOR;
                        state_next = rcr_pkg::RCR_RUN;
                    end
                end
                default: begin
                    state_next = state_reg;
                end
            endcase
        end
    end

    // Registers only; synchronous reset loads the power-on flag values but pulses no core_reset or pc_load
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= rcr_pkg::RCR_RUN;
            time_out_flag_reg <= rcr_pkg::RCR_TO_POR;
            power_down_flag_reg <= rcr_pkg::RCR_PD_POR;
            power_control_register_reg <= rcr_pkg::RCR_POWER_CONTROL_REGISTER_POR;
            ctrl_reg <= rcr_pkg::RCR_CTRL_RST;
            pc_value_reg <= rcr_pkg::RCR_RESET_ADDR;
            return_addr_reg <= rcr_pkg::RCR_RESET_ADDR;
            core_reset_reg <= 1'b0;
            pc_load_reg <= 1'b0;
            return_push_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            time_out_flag_reg <= time_out_flag_next;
            power_down_flag_reg <= power_down_flag_next;
            power_control_register_reg <= power_control_register_next;
            ctrl_reg <= ctrl_next;
            pc_value_reg <= pc_value_next;
            return_addr_reg <= return_addr_next;
            core_reset_reg <= core_reset_next;
            pc_load_reg <= pc_load_next;
            return_push_reg <= return_push_next;
        end
    end

    assign core_reset = core_reset_reg;
    assign pc_load = pc_load_reg;
    assign pc_value = pc_value_reg;
    assign return_push = return_push_reg;
    assign return_addr = return_addr_reg;
    assign asleep = in_sleep;

    // ==========================================================
    // Read mux; unmapped offsets read zero
    always_comb begin
        case (avs_address)
            rcr_pkg::RCR_OFS_STATUS: begin
                rd_value = 32'h0000_0000;
                rd_value[rcr_pkg::RCR_ST_TO] = time_out_flag_reg;
                rd_value[rcr_pkg::RCR_ST_PD] = power_down_flag_reg;
            end
            rcr_pkg::RCR_OFS_POWER_CONTROL_REGISTER: begin
                rd_value = {24'h00_0000, power_control_register_reg};
            end
            rcr_pkg::RCR_OFS_CTRL: begin
                rd_value = {30'h0000_0000, ctrl_reg};
            end
            rcr_pkg::RCR_OFS_RESUME: begin
                rd_value = {16'h0000, pc_value_reg};
            end
            rcr_pkg::RCR_OFS_IRQ_STAT: begin
                rd_value = {24'h00_0000, irq_status};
            end
            rcr_pkg::RCR_OFS_IRQ_MASK: begin
                rd_value = {24'h00_0000, irq_mask};
            end
            default: begin
                rd_value = 32'h0000_0000;
            end
        endcase
    end

    // ==========================================================
    // Bus slave and event interrupt
    rcr_avmm_slave u_slave (
        .clk(clk),
        .sys_rst(sys_rst),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .rd_value(rd_value),
        .wr_en(wr_en)
    );

    assign ev_set = {sel_wake, sel_soft, sel_unf, sel_ovf,
                     sel_wdt, sel_pin, sel_bor, sel_por};

    rcr_sticky_irq #(.W(rcr_pkg::RCR_EV_W)) u_irq (
        .clk(clk),
        .sys_rst(sys_rst),
        .set(ev_set),
        .clr_wr(lane0 && avs_address == rcr_pkg::RCR_OFS_IRQ_STAT),
        .mask_wr(lane0 && avs_address == rcr_pkg::RCR_OFS_IRQ_MASK),
        .wdata(avs_writedata[7:0]),
        .status(irq_status),
        .mask(irq_mask),
        .irq(irq)
    );

    // ==========================================================
    // Checks
    property p_por;
        @(posedge clk) disable iff (sys_rst)
        sel_por |=> power_control_register_reg == rcr_pkg::RCR_POWER_CONTROL_REGISTER_POR
            && time_out_flag_reg && pc_load && pc_value == 16'h0000;
    endproperty
    a_por: assert property (p_por)
        else $error("power-on flags or address wrong");

    property p_por_pd;
        @(posedge clk) disable iff (sys_rst)
        sel_por |=> power_down_flag_reg
            && !power_control_register_reg[rcr_pkg::RCR_PC_POR_N];
    endproperty
    a_por_pd: assert property (p_por_pd)
        else $error("power-down not set by power-on");

    property p_wdt_wake;
        @(posedge clk) disable iff (sys_rst)
        (sel_wdt && in_sleep) |=> !time_out_flag_reg && !power_down_flag_reg
            && pc_value == $past(cur_pc) + 16'h0001 && !core_reset;
    endproperty
    a_wdt_wake: assert property (p_wdt_wake)
        else $error("watchdog wake handled wrong");

    property p_int_wake;
        @(posedge clk) disable iff (sys_rst)
        sel_wake |=> time_out_flag_reg && !power_down_flag_reg && pc_load
            && pc_value == $past(cur_pc) + 16'h0001;
    endproperty
    a_int_wake: assert property (p_int_wake)
        else $error("interrupt wake handled wrong");

    property p_pin_run;
        @(posedge clk) disable iff (sys_rst)
        (sel_pin && !in_sleep) |=> core_reset && pc_value == 16'h0000
            && !power_control_register_reg[rcr_pkg::RCR_PC_PIN_N]
            && $stable(time_out_flag_reg) && $stable(power_down_flag_reg);
    endproperty
    a_pin_run: assert property (p_pin_run)
        else $error("pin reset while running wrong");

    property p_pin_sleep;
        @(posedge clk) disable iff (sys_rst)
        (sel_pin && in_sleep) |=> time_out_flag_reg && !power_down_flag_reg
            && !power_control_register_reg[rcr_pkg::RCR_PC_PIN_N] && !asleep;
    endproperty
    a_pin_sleep: assert property (p_pin_sleep)
        else $error("pin reset while asleep wrong");

    property p_ovf;
        @(posedge clk) disable iff (sys_rst)
        sel_ovf |=> power_control_register_reg[rcr_pkg::RCR_PC_OVF]
            && core_reset && pc_value == 16'h0000;
    endproperty
    a_ovf: assert property (p_ovf)
        else $error("stack overflow reset wrong");

    property p_unf;
        @(posedge clk) disable iff (sys_rst)
        sel_unf |=> power_control_register_reg[rcr_pkg::RCR_PC_UNF]
            && core_reset && pc_value == 16'h0000;
    endproperty
    a_unf: assert property (p_unf)
        else $error("stack underflow reset wrong");

    property p_vector;
        @(posedge clk) disable iff (sys_rst)
        (state_reg == rcr_pkg::RCR_WAKE_EXEC && instr_done
            && !(por_event || bor_event || external_reset_pin || wdt_timeout
            || soft_reset || stack_overflow || stack_underflow))
            |=> return_push && pc_value == 16'h0004
            && return_addr == $past(pc_value) + 16'h0001;
    endproperty
    a_vector: assert property (p_vector)
        else $error("interrupt vector not taken after one instruction");

    property p_wdt_run;
        @(posedge clk) disable iff (sys_rst)
        (sel_wdt && !in_sleep) |=> core_reset && !time_out_flag_reg
            && !power_control_register_reg[rcr_pkg::RCR_PC_WDT_N];
    endproperty
    a_wdt_run: assert property (p_wdt_run)
        else $error("watchdog reset flags wrong");

    property p_bor;
        @(posedge clk) disable iff (sys_rst)
        sel_bor |=> !power_control_register_reg[rcr_pkg::RCR_PC_BOR_N]
            && time_out_flag_reg && power_down_flag_reg && core_reset;
    endproperty
    a_bor: assert property (p_bor)
        else $error("brown-out flags wrong");

endmodule

// File: design/rcr_pkg.sv
package rcr_pkg;

    // ==========================================================
    // Register byte offsets on the Avalon-MM slave
    localparam logic [5:0] RCR_OFS_STATUS = 6'h00;
    localparam logic [5:0] RCR_OFS_POWER_CONTROL_REGISTER = 6'h04;
    localparam logic [5:0] RCR_OFS_CTRL = 6'h08;
    localparam logic [5:0] RCR_OFS_RESUME = 6'h0C;
    localparam logic [5:0] RCR_OFS_IRQ_STAT = 6'h10;
    localparam logic [5:0] RCR_OFS_IRQ_MASK = 6'h14;

    // ==========================================================
    // Status register field positions
    localparam int RCR_ST_TO = 4;
    localparam int RCR_ST_PD = 3;

    // ==========================================================
    // Power-control register field positions
    localparam int RCR_PC_OVF = 7;
    localparam int RCR_PC_UNF = 6;
    localparam int RCR_PC_WDT_N = 4;
    localparam int RCR_PC_PIN_N = 3;
    localparam int RCR_PC_SOFT_N = 2;
    localparam int RCR_PC_POR_N = 1;
    localparam int RCR_PC_BOR_N = 0;
    // Writable bits of the power-control register
    localparam logic [7:0] RCR_POWER_CONTROL_REGISTER_WMASK = 8'hDF;

    // ==========================================================
    // Control register field positions
    localparam int RCR_CT_STKEN = 0;
    localparam int RCR_CT_GIE = 1;

    // ==========================================================
    // Reset values
    localparam logic [7:0] RCR_POWER_CONTROL_REGISTER_POR = 8'h1D;
    localparam logic RCR_TO_POR = 1'b1;
    localparam logic RCR_PD_POR = 1'b1;
    localparam logic [1:0] RCR_CTRL_RST = 2'h0;
    localparam logic [7:0] RCR_IRQ_MASK_RST = 8'h00;

    // ==========================================================
    // Program addresses
    localparam logic [15:0] RCR_RESET_ADDR = 16'h0000;
    localparam logic [15:0] RCR_INT_VECTOR = 16'h0004;
    localparam logic [15:0] RCR_PC_STEP = 16'h0001;

    // ==========================================================
    // Event bit positions in the interrupt status register
    localparam int RCR_EV_POR = 0;
    localparam int RCR_EV_BOR = 1;
    localparam int RCR_EV_PIN = 2;
    localparam int RCR_EV_WDT = 3;
    localparam int RCR_EV_OVF = 4;
    localparam int RCR_EV_UNF = 5;
    localparam int RCR_EV_SOFT = 6;
    localparam int RCR_EV_WAKE = 7;
    localparam int RCR_EV_W = 8;

    // ==========================================================
    // Core run state
    typedef enum logic [1:0] {
        RCR_RUN,
        RCR_SLEEP,
        RCR_WAKE_EXEC
    } rcr_state_t;

endpackage

// File: design/rcr_avmm_slave.sv
`timescale 1ns/100ps
module rcr_avmm_slave (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Avalon-MM slave
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Register file side
    input wire logic [31:0] rd_value,
    output logic wr_en
);

    // ==========================================================
    // One wait state: capture in the first cycle, release next
    logic ack_reg;
    logic ack_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic req;

    assign req = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_reg;
    assign wr_en = avs_write & ack_reg;
    assign avs_readdata = rdata_reg;

    // Next ack and read capture
    always_comb begin
        ack_next = req & ~ack_reg;
        rdata_next = rdata_reg;
        if (avs_read && !ack_reg) begin
            rdata_next = rd_value; // Stable by the time waitrequest drops
        end
    end

    // Registers only
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;
        end
    end

endmodule

// File: design/rcr_sticky_irq.sv
`timescale 1ns/100ps
module rcr_sticky_irq #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Events and software access
    input wire logic [W-1:0] set,
    input wire logic clr_wr,
    input wire logic mask_wr,
    input wire logic [W-1:0] wdata,
    // State and interrupt
    output logic [W-1:0] status,
    output logic [W-1:0] mask,
    output logic irq
);

    // ==========================================================
    // Sticky bits, write one to clear; a set in the same cycle wins
    logic [W-1:0] status_reg;
    logic [W-1:0] status_next;
    logic [W-1:0] mask_reg;
    logic [W-1:0] mask_next;

    always_comb begin
        status_next = status_reg;
        if (clr_wr) begin
            status_next = status_next & ~wdata;
        end
        status_next = status_next | set;
        mask_next = mask_wr ? wdata : mask_reg;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            status_reg <= '0;
            mask_reg <= W'(rcr_pkg::RCR_IRQ_MASK_RST);
        end else begin
            status_reg <= status_next;
            mask_reg <= mask_next;
        end
    end

    assign status = status_reg;
    assign mask = mask_reg;
    assign irq = |(status_reg & mask_reg);

endmodule

// File: dv/tb_rcr_top.sv
`timescale 1ns/100ps
module tb_rcr_top;
    // ==========================================
    // Stimulus, responses and score
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [8:0] ev = 9'h000;
    logic done = 1'b0;
    logic [15:0] cur_pc = 16'h0000;
    logic [5:0] adr = 6'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0000_0000;
    logic core_reset, pc_load, return_push, asleep, wreq, irq;
    logic [15:0] pc_value, return_addr;
    logic [15:0] exp_pc;
    logic [31:0] rdata, got;
    logic [9:0] f = 10'h31D;
    logic [12:0] m;
    logic slp = 1'b0;
    logic en = 1'b0;
    int seed = 32'h724216b7;
    int bad_count = 0;
    int cmp_count = 0;
    int k;

    // Free running 20 MHz clock
    always #25 clk = ~clk;

    rcr_top uut (.clk(clk), .sys_rst(sys_rst), .por_event(ev[8]),
        .bor_event(ev[7]), .external_reset_pin(ev[6]),
        .wdt_timeout(ev[5]), .stack_overflow(ev[4]),
        .stack_underflow(ev[3]), .soft_reset(ev[2]),
        .wake_interrupt(ev[1]), .sleep_cmd(ev[0]), .cur_pc(cur_pc),
        .instr_done(done), .core_reset(core_reset), .pc_load(pc_load),
        .pc_value(pc_value), .return_push(return_push),
        .return_addr(return_addr), .asleep(asleep), .avs_address(adr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
        .avs_byteenable(4'hF), .avs_readdata(rdata),
        .avs_waitrequest(wreq), .irq(irq));

    task chk(input string nm, input logic [31:0] ex, input logic [31:0] s);
        cmp_count++;
        if (s !== ex) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, s);
        end
    endtask

    task print_verdict();
        $display("Checks %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // One bus cycle; the request holds until waitrequest is seen low
    task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a; wd <= d; wr <= w; rd <= ~w;
        #1;
        // Only the watchdog ends a wait that never sees waitrequest low
        while (wreq !== 1'b0) begin
            @(posedge clk); #1;
        end
        @(posedge clk);
        got = rdata;
        rd <= 1'b0; wr <= 1'b0;
    endtask

    // Event k as a one cycle pulse: 0 por .. 7 wake, 8 sleep
    task fire(input int k);
        @(posedge clk); ev <= 9'h100 >> k;
        @(posedge clk); ev <= 9'h000; #1;
    endtask

    // Expected {load, wake, asleep, TO, PD, power control}
    function automatic logic [12:0] model(int k, logic s, logic t,
                                          logic [9:0] v);
        logic ld, wk;
        ld = 1'b1; wk = 1'b0;
        case (k)
            0: v = 10'h31D;
            1: v = {4'hC, v[5:4], 2'b11, v[1], 1'b0};
            2: v = {s ? 2'b10 : v[9:8], v[7:4], 1'b0, v[2:0]};
            3: if (s) begin v[9:8] = 2'b00; wk = 1'b1; end
               else begin v[9] = 1'b0; v[4] = 1'b0; end
            4: begin ld = t; v[7] = v[7] | t; end
            5: begin ld = t; v[6] = v[6] | t; end
            6: v[2] = 1'b0;
            7: begin ld = s; wk = s; if (s) v[9:8] = 2'b10; end
            default: begin ld = 1'b0; if (!s) v[9:8] = 2'b10; end
        endcase
        return {ld, wk, (k == 8) | (s & ~ld), v};
    endfunction

    // Guard against a hung handshake
    initial begin
        #400000; bad_count++; print_verdict();
    end

    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        bus(0, 6'h00, 0); chk("status", 32'h18, got);
        bus(0, 6'h04, 0); chk("power_control_register", 32'h1D, got);
        bus(0, 6'h18, 0); chk("unmapped", 0, got);
        $display("reset values done");
        for (int i = 0; i < 40; i++) begin
            en = $random(seed);
            bus(1, 6'h08, {31'h0, en});
            k = ($random(seed) & 32'hFF) % 9;
            if (slp) k = (k % 3 == 0) ? 2 : ((k % 3 == 1) ? 3 : 7);
            cur_pc <= $random(seed);
            m = model(k, slp, en, f);
            fire(k);
            chk("pc_load", m[12], pc_load);
            // Resume address wraps at 16 bits like the program counter
            exp_pc = m[11] ? 16'(cur_pc + 16'h0001) : 16'h0000;
            if (m[12]) chk("pc_value", exp_pc, pc_value);
            chk("core_reset", m[12] & ~m[11], core_reset);
            slp = m[10]; f = m[9:0];
            chk("asleep", slp, asleep);
            bus(0, 6'h00, 0); chk("status", {f[9:8], 3'b0}, got);
            bus(0, 6'h04, 0); chk("power_control_register", f[7:0], got);
        end
        $display("random events done");
        bus(1, 6'h10, 32'hFF); bus(1, 6'h14, 0); fire(6);
        bus(0, 6'h10, 0); chk("irq_stat", 32'h40, got);
        chk("irq masked", 0, irq);
        bus(1, 6'h14, 32'h40);
        #1;
        chk("irq", 1, irq);
        bus(1, 6'h10, 32'h40);
        #1;
        chk("irq cleared", 0, irq);
        bus(1, 6'h00, 0); bus(0, 6'h00, 0);
        chk("status ro", {f[9:8], 3'b0}, got);
        $display("interrupt done");
        bus(1, 6'h08, 32'h2); fire(8);
        cur_pc <= $random(seed); fire(7);
        exp_pc = 16'(cur_pc + 16'h0001);
        chk("wake pc", exp_pc, pc_value);
        @(posedge clk); done <= 1'b1; @(posedge clk); done <= 1'b0; #1;
        chk("push", 1, return_push);
        chk("vector", 16'h0004, pc_value);
        exp_pc = 16'(cur_pc + 16'h0002);
        chk("return", exp_pc, return_addr);
        bus(0, 6'h0C, 0); chk("resume", 32'h0004, got);
        $display("vector done");
        print_verdict();
    end
endmodule
